// [logic/fdcd_top.sv]
// apb register file, filter timing, power-up states, change detection and status led
`timescale 1ns/1ns
module fdcd_top
  import fdcd_pkg::*;
#(
  parameter int FILT_HALF_MAX = FILT_HALF_MAX_CYC,
  parameter int BLINK_HALF = BLINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LINES-1:0] line_in,
  output logic [NUM_LINES-1:0] line_out,
  output logic [NUM_LINES-1:0] line_oe,
  output logic [NUM_LINES-1:0] pull_active,
  input wire logic suspend,
  input wire logic power_fault,
  output logic change_irq,
  output logic change_overflow,
  output logic power_activity_indicator
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fdcd_state_e st;
    logic run_d;
    logic [CFG_AW-1:0] cfg_idx;
    logic [HALF_W-1:0] filt_half;
    logic [HALF_W-1:0] tick_cnt;
    logic filt_tick;
    logic [NUM_LINES-1:0] filt_en;
    logic [NUM_LINES-1:0] rise_en;
    logic [NUM_LINES-1:0] fall_en;
    logic [NUM_LINES-1:0] drv_oe;
    logic [NUM_LINES-1:0] drv_val;
    logic [NUM_LINES-1:0] pu_drv;
    logic [NUM_LINES-1:0] pull_active;
    logic [NUM_LINES-1:0] prev;
    logic [NUM_LINES-1:0] snap;
    logic pend;
    logic ovf;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink;
    logic led;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fdcd_top_s;

  localparam logic [HALF_W-1:0] HALF_MIN = HALF_W'(FILT_HALF_MIN_CYC);
  localparam logic [HALF_W-1:0] HALF_MAX = HALF_W'(FILT_HALF_MAX);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF - 1);

  fdcd_top_s s;
  fdcd_top_s next_s;

  logic [NUM_LINES-1:0] filt_out;
  logic [31:0] cfg_rdata;
  logic cfg_we;
  logic [CFG_AW-1:0] cfg_waddr;
  logic [CFG_AW-1:0] cfg_raddr;

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (a < (base + 8'(4 * n)));
  endfunction : in_rng

  function automatic int widx(input logic [7:0] a, input logic [7:0] base);
    return int'((a - base) >> 2);
  endfunction : widx

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  fdcd_glitch_filter #(
    .N(NUM_LINES)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .line_in(line_in),
    .filt_en(s.filt_en),
    .filt_tick(s.filt_tick),
    .filt_out(filt_out)
  );

  fdcd_cfg_mem #(
    .DEPTH(CFG_WORDS),
    .W(32),
    .AW(CFG_AW)
  ) u_cfg (
    .pclk(pclk),
    .presetn(presetn),
    .we(cfg_we),
    .waddr(cfg_waddr),
    .wdata(pwdata),
    .raddr(cfg_raddr),
    .rdata(cfg_rdata)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic acc;
  logic [HALF_W-1:0] half;
  logic [NUM_LINES-1:0] edges;
  logic [NUM_LINES-1:0] watched;
  logic [NUM_LINES-1:0] in_view;
  logic ev;
  logic ack;
  logic [31:0] rd;
  logic err;
  logic [1:0] code;
  int ln;

  assign acc = psel && penable && !s.pready && (s.st == ST_RUN) && s.run_d;
  assign cfg_we = acc && pwrite && in_rng(paddr, OFF_PWRUP0, CFG_WORDS);
  assign cfg_waddr = CFG_AW'(widx(paddr, OFF_PWRUP0));
  assign cfg_raddr = (s.st != ST_RUN) ? s.cfg_idx : CFG_AW'(widx(paddr, OFF_PWRUP0));

  always_comb begin
    next_s = s;
    half = s.filt_half;
    rd = 32'h0;
    err = 1'b0;
    code = PU_HIZ;
    ln = 0;
    ack = 1'b0;

    // filter tick divider, clamped to legal interval
    if (half < HALF_MIN) begin
      half = HALF_MIN;
    end else if (half > HALF_MAX) begin
      half = HALF_MAX;
    end
    if (s.tick_cnt >= (half - HALF_W'(1))) begin
      next_s.tick_cnt = '0;
      next_s.filt_tick = 1'b1;
    end else begin
      next_s.tick_cnt = HALF_W'(s.tick_cnt + HALF_W'(1));
      next_s.filt_tick = 1'b0;
    end

    // power-up state loader
    next_s.run_d = (s.st == ST_RUN);
    case (s.st)
      ST_LOAD: begin
        next_s.st = ST_TAKE;
      end
      ST_TAKE: begin
        for (int j = 0; j < CFG_PER_WORD; j++) begin
          code = cfg_rdata[2*j +: 2];
          ln = int'(s.cfg_idx) * CFG_PER_WORD + j;
          next_s.drv_oe[ln] = (code == PU_HIGH) || (code == PU_LOW);
          next_s.drv_val[ln] = (code == PU_HIGH);
          next_s.pu_drv[ln] = (code == PU_HIGH) || (code == PU_LOW);
        end
        if (int'(s.cfg_idx) == CFG_WORDS - 1) begin
          next_s.st = ST_RUN;
          next_s.cfg_idx = '0;
        end else begin
          next_s.st = ST_LOAD;
          next_s.cfg_idx = CFG_AW'(s.cfg_idx + CFG_AW'(1));
        end
      end
      ST_RUN: begin
        next_s.st = ST_RUN;
      end
      default: begin
        next_s.st = ST_RUN;
      end
    endcase

    // pull selector only governs lines without a power-up drive code in force
    next_s.pull_active = ~s.pu_drv;

    // change detection
    edges = (filt_out & ~s.prev & s.rise_en) | (~filt_out & s.prev & s.fall_en);
    ev = |edges;
    watched = s.rise_en | s.fall_en;
    in_view = (watched & s.snap) | (~watched & filt_out);
    next_s.prev = filt_out;
    if (ev) begin
      next_s.snap = filt_out;
    end

    // apb access
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (acc) begin
      next_s.pready = 1'b1;
      if (paddr == OFF_CTRL) begin
        if (pwrite) begin
          ack = pwdata[CTRL_ACK_BIT];
          if (pwdata[CTRL_APPLY_BIT]) begin
            next_s.st = ST_LOAD;
            next_s.cfg_idx = '0;
          end
        end
      end else if (paddr == OFF_STATUS) begin
        rd[STAT_PEND_BIT] = s.pend;
        rd[STAT_OVF_BIT] = s.ovf;
        rd[STAT_APPLY_BIT] = (s.st != ST_RUN);
        rd[STAT_FAULT_BIT] = power_fault;
      end else if (paddr == OFF_FILT_HALF) begin
        rd[HALF_W-1:0] = s.filt_half;
        if (pwrite) begin
          next_s.filt_half = pwdata[HALF_W-1:0];
        end
      end else if (paddr == OFF_DIR) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          rd[p] = s.drv_oe[p*LINES_PER_PORT];
          if (pwrite) begin
            next_s.drv_oe[p*LINES_PER_PORT +: LINES_PER_PORT] = {LINES_PER_PORT{pwdata[p]}};
          end
        end
        if (pwrite) begin
          next_s.pu_drv = '0;
        end
      end else if (in_rng(paddr, OFF_FILT_EN0, DATA_WORDS)) begin
        rd = s.filt_en[widx(paddr, OFF_FILT_EN0)*32 +: 32];
        if (pwrite) begin
          next_s.filt_en[widx(paddr, OFF_FILT_EN0)*32 +: 32] = pwdata;
        end
      end else if (in_rng(paddr, OFF_RISE_EN0, DATA_WORDS)) begin
        rd = s.rise_en[widx(paddr, OFF_RISE_EN0)*32 +: 32];
        if (pwrite) begin
          next_s.rise_en[widx(paddr, OFF_RISE_EN0)*32 +: 32] = pwdata;
        end
      end else if (in_rng(paddr, OFF_FALL_EN0, DATA_WORDS)) begin
        rd = s.fall_en[widx(paddr, OFF_FALL_EN0)*32 +: 32];
        if (pwrite) begin
          next_s.fall_en[widx(paddr, OFF_FALL_EN0)*32 +: 32] = pwdata;
        end
      end else if (in_rng(paddr, OFF_OUT_DATA0, DATA_WORDS)) begin
        rd = s.drv_val[widx(paddr, OFF_OUT_DATA0)*32 +: 32];
        if (pwrite) begin
          next_s.drv_val[widx(paddr, OFF_OUT_DATA0)*32 +: 32] = pwdata;
        end
      end else if (in_rng(paddr, OFF_IN_DATA0, DATA_WORDS)) begin
        rd = in_view[widx(paddr, OFF_IN_DATA0)*32 +: 32];
      end else if (in_rng(paddr, OFF_PWRUP0, CFG_WORDS)) begin
        rd = cfg_rdata;
      end else begin
        err = 1'b1;
      end
      next_s.prdata = pwrite ? 32'h0 : rd;
      next_s.pslverr = err;
    end

    // pending event and overflow; a new edge wins over acknowledge
    next_s.ovf = (s.ovf && !ack) || (ev && s.pend);
    next_s.pend = (s.pend && !ack) || ev;

    // status led
    if (s.blink_cnt >= BLINK_LAST) begin
      next_s.blink_cnt = '0;
      next_s.blink = !s.blink;
    end else begin
      next_s.blink_cnt = BLINK_W'(s.blink_cnt + BLINK_W'(1));
    end
    if (suspend) begin
      next_s.led = 1'b0;
    end else if (power_fault) begin
      next_s.led = s.blink;
    end else begin
      next_s.led = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0; // drivers off, all lines input
      s.st <= ST_LOAD;
      s.filt_half <= HALF_MIN;
      s.pull_active <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign line_out = s.drv_val;
  assign line_oe = s.drv_oe;
  assign pull_active = s.pull_active;
  assign change_irq = s.pend;
  assign change_overflow = s.ovf;
  assign power_activity_indicator = s.led;

endmodule : fdcd_top

// [logic/fdcd_pkg.sv]
// constants, register map and types for the filtered dio change detect block
package fdcd_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 96;
  localparam int NUM_PORTS = 12;
  localparam int LINES_PER_PORT = 8;
  localparam int DATA_WORDS = 3;
  localparam int CFG_WORDS = 6;
  localparam int CFG_PER_WORD = 16;
  localparam int CFG_AW = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_HZ = 48_000_000;
  localparam int SAMPLE_PERIOD_PS = 20_830;
  localparam int FILT_MIN_NS = 200;
  localparam int FILT_MAX_MS = 200;
  localparam int FILT_HALF_MIN_CYC = (FILT_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_HALF_MAX_CYC = FILT_MAX_MS * 1_000_000 / 2 / CLK_PERIOD_NS;
  localparam int HALF_W = 23;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int BLINK_W = 24;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FILT_HALF = 8'h08;
  localparam logic [7:0] OFF_DIR = 8'h0C;
  localparam logic [7:0] OFF_FILT_EN0 = 8'h10;
  localparam logic [7:0] OFF_RISE_EN0 = 8'h1C;
  localparam logic [7:0] OFF_FALL_EN0 = 8'h28;
  localparam logic [7:0] OFF_OUT_DATA0 = 8'h34;
  localparam logic [7:0] OFF_IN_DATA0 = 8'h40;
  localparam logic [7:0] OFF_PWRUP0 = 8'h50;

  // ----------------------------------------------------------------
  // fields and codes
  // ----------------------------------------------------------------
  localparam int CTRL_APPLY_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_APPLY_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam logic [1:0] PU_HIZ = 2'h0;
  localparam logic [1:0] PU_HIGH = 2'h1;
  localparam logic [1:0] PU_LOW = 2'h2;

  typedef enum logic [2:0] {
    ST_LOAD = 3'h1,
    ST_TAKE = 3'h2,
    ST_RUN = 3'h4
  } fdcd_state_e;

endpackage : fdcd_pkg

// [logic/fdcd_cfg_mem.sv]
// small memory holding the per-line power-up settings
`timescale 1ns/1ns
module fdcd_cfg_mem #(
  parameter int DEPTH = 6,
  parameter int W = 32,
  parameter int AW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } fdcd_mem_s;

  fdcd_mem_s s;
  fdcd_mem_s next_s;

  always_comb begin
    next_s = s;
    if (we && (int'(waddr) < DEPTH)) begin
      next_s.mem[waddr] = wdata;
    end
    if (int'(raddr) < DEPTH) begin
      next_s.rdata = s.mem[raddr];
    end else begin
      next_s.rdata = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

endmodule : fdcd_cfg_mem

// [logic/fdcd_glitch_filter.sv]
// per-line sampling and glitch filter
`timescale 1ns/1ns
module fdcd_glitch_filter #(
  parameter int N = 96
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] line_in,
  input wire logic [N-1:0] filt_en,
  input wire logic filt_tick,
  output logic [N-1:0] filt_out
);

  typedef struct packed {
    logic [N-1:0] samp;
    logic [N-1:0] held;
    logic [N-1:0] broke;
    logic [N-1:0] fval;
  } fdcd_filt_s;

  fdcd_filt_s s;
  fdcd_filt_s next_s;

  always_comb begin
    next_s = s;
    next_s.samp = line_in;
    for (int i = 0; i < N; i++) begin
      if (!filt_en[i]) begin
        next_s.fval[i] = s.samp[i];
        next_s.held[i] = s.samp[i];
        next_s.broke[i] = 1'b0;
      end else if (filt_tick) begin
        // level must be steady from one tick to the next
        if (!s.broke[i] && (s.samp[i] == s.held[i])) begin
          next_s.fval[i] = s.samp[i]; // same for both polarities
        end
        next_s.held[i] = s.samp[i];
        next_s.broke[i] = 1'b0;
      end else if (s.samp[i] != s.held[i]) begin
        next_s.broke[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign filt_out = s.fval;

endmodule : fdcd_glitch_filter

// [testbench/fdcd_monitor.sv]
// concurrent checks on the ports of the filtered dio change detect block
`timescale 1ns/1ns
module fdcd_monitor
  import fdcd_pkg::*;
#(
  parameter int BLINK_HALF = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_LINES-1:0] line_oe,
  input wire logic suspend,
  input wire logic power_fault,
  input wire logic change_irq,
  input wire logic change_overflow,
  input wire logic power_activity_indicator
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // helper: cycles the led has held still while faulted
  // ----------------------------------------------------------------
  int still_cnt;
  logic led_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      still_cnt <= 0;
      led_q <= 1'b0;
    end else begin
      led_q <= power_activity_indicator;
      if (!power_fault || suspend || power_activity_indicator != led_q) begin
        still_cnt <= 0;
      end else begin
        still_cnt <= still_cnt + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus, flag and led properties
  // ----------------------------------------------------------------
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_quiet;
    !suspend && !power_fault;
  endsequence

  a_ready_bound: assert property (s_access |-> ##[1:20] pready)
    else $error("access not answered in time");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_wr_zero: assert property (pready && pwrite |-> prdata == 32'h00000000)
    else $error("read data not zero on write");
  a_oe_reset: assert property (!$past(presetn) |-> line_oe == '0)
    else $error("drive enabled right after reset");
  a_ovf_pend: assert property (change_overflow |-> change_irq)
    else $error("overflow without pending event");
  a_ovf_rise: assert property ($rose(change_overflow) |-> $past(change_irq))
    else $error("overflow set with nothing pending");
  a_led_dark: assert property (suspend [*2] |-> !power_activity_indicator)
    else $error("led lit while suspended");
  a_led_lit: assert property ((s_quiet [*2] ##0 $past(presetn)) |-> power_activity_indicator)
    else $error("led dark in normal operation");
  a_led_blink: assert property (still_cnt <= BLINK_HALF + 3)
    else $error("led not blinking on fault");
endmodule : fdcd_monitor

// [testbench/fdcd_field.sv]
// field side of the lines: external sources, pull resistors, device drive
`timescale 1ns/1ns
module fdcd_field
  import fdcd_pkg::*;
#(
  parameter bit PULL_HIGH = 1'b0
) (
  input wire logic [NUM_LINES-1:0] line_out,
  input wire logic [NUM_LINES-1:0] line_oe,
  output logic [NUM_LINES-1:0] line_in
);
  logic [NUM_LINES-1:0] ext_en = '0;
  logic [NUM_LINES-1:0] ext_val = '0;

  // ----------------------------------------------------------------
  // wire level: device drive, then external source, else pull
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (line_oe[i]) begin
        line_in[i] = line_out[i];
      end else if (ext_en[i]) begin
        line_in[i] = ext_val[i];
      end else begin
        line_in[i] = PULL_HIGH;
      end
    end
  end

  task automatic set_line(input int i, input logic v);
    ext_en[i] <= 1'b1;
    ext_val[i] <= v;
  endtask : set_line
endmodule : fdcd_field

// [testbench/filtered_dio_change_detect_test.sv]
// self-checking bench for the filtered dio change detect block
`timescale 1ns/1ns
module filtered_dio_change_detect_test
  import fdcd_pkg::*;
;
  localparam int HALF = 10;
  localparam int BLINK = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic suspend = 1'b0;
  logic power_fault = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_LINES-1:0] line_in;
  logic [NUM_LINES-1:0] line_out;
  logic [NUM_LINES-1:0] line_oe;
  logic [NUM_LINES-1:0] pull_active;
  logic change_irq;
  logic change_overflow;
  logic power_activity_indicator;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] seed = 32'hEE5C4187;
  logic [31:0] mdl [logic [7:0]];
  logic [31:0] rd;
  logic err;

  fdcd_top #(.FILT_HALF_MAX(50), .BLINK_HALF(BLINK)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .pull_active(pull_active),
    .suspend(suspend), .power_fault(power_fault), .change_irq(change_irq),
    .change_overflow(change_overflow), .power_activity_indicator(power_activity_indicator)
  );
  fdcd_field #(.PULL_HIGH(1'b0)) u_field (
    .line_out(line_out), .line_oe(line_oe), .line_in(line_in)
  );

  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mdl[a] = d;
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
    chk($sformatf("reg %h", a), mdl[a], rd);
  endtask : rdc

  task automatic ack();
    apb(1'b1, OFF_CTRL, 32'h00000002);
    @(posedge pclk);
    chk("irq after ack", 1'b0, change_irq);
    chk("overflow after ack", 1'b0, change_overflow);
  endtask : ack

  task automatic wait_irq(input logic exp, input int n, input string nm);
    int k;
    k = 0;
    while (change_irq !== 1'b1 && k < n) begin
      @(posedge pclk);
      k++;
    end
    chk(nm, exp, change_irq);
  endtask : wait_irq

  task automatic pulse(input int i, input logic v, input int w);
    @(posedge pclk);
    u_field.set_line(i, v);
    repeat (w) @(posedge pclk);
    u_field.set_line(i, !v);
  endtask : pulse

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    logic prev;
    for (int a = 0; a < 8'h4C; a += 4) mdl[a[7:0]] = 32'h00000000;
    mdl[OFF_FILT_HALF] = 32'h00000005;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (14) @(posedge pclk);
    chk("oe after reset", '0, line_oe);
    chk("pull after reset", '1, pull_active);
    foreach (mdl[a]) rdc(a);
    apb(1'b0, 8'h4C, 32'h00000000);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h00000000, rd);
    for (int w = 0; w < 3; w++) begin
      wr(OFF_OUT_DATA0 + 8'(4 * w), rnd());
      rdc(OFF_OUT_DATA0 + 8'(4 * w));
    end
    $display("registers done");
    wr(OFF_FILT_HALF, HALF);
    wr(OFF_FILT_EN0, 32'h00000001);
    wr(OFF_RISE_EN0, 32'h00000001);
    wr(OFF_FALL_EN0, 32'h00000001);
    pulse(0, 1'b1, HALF - 2);
    wait_irq(1'b0, 3 * HALF, "narrow high");
    pulse(0, 1'b0, 1);
    @(posedge pclk);
    wait_irq(1'b1, 2 * HALF + 6, "wide rise");
    mdl[OFF_IN_DATA0] = 32'h00000001;
    rdc(OFF_IN_DATA0);
    ack();
    pulse(0, 1'b0, HALF - 2);
    wait_irq(1'b0, 3 * HALF, "narrow low");
    u_field.set_line(0, 1'b0);
    wait_irq(1'b1, 2 * HALF + 6, "wide fall");
    ack();
    $display("filter done");
    wr(OFF_RISE_EN0 + 8'h04, 32'h00000100);
    pulse(40, 1'b1, 1);
    wait_irq(1'b1, 4, "raw rise");
    @(posedge pclk);
    u_field.set_line(41, 1'b1);
    repeat (6) @(posedge pclk);
    chk("no overflow", 1'b0, change_overflow);
    pulse(40, 1'b1, 1);
    repeat (5) @(posedge pclk);
    chk("overflow", 1'b1, change_overflow);
    mdl[OFF_STATUS] = 32'h00000003;
    rdc(OFF_STATUS);
    mdl[OFF_IN_DATA0 + 8'h04] = 32'h00000300;
    rdc(OFF_IN_DATA0 + 8'h04);
    ack();
    $display("detection done");
    wr(OFF_PWRUP0, 32'h00000009);
    chk("oe before apply", '0, line_oe);
    apb(1'b1, OFF_CTRL, 32'h00000001);
    repeat (14) @(posedge pclk);
    chk("oe applied", 3'b011, line_oe[2:0]);
    chk("out applied", 2'b01, line_out[1:0]);
    chk("pull applied", 3'b100, pull_active[2:0]);
    wait_irq(1'b1, 2 * HALF + 12, "driven rise seen");
    ack();
    $display("power-up done");
    chk("led normal", 1'b1, power_activity_indicator);
    suspend <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("led suspend", 1'b0, power_activity_indicator);
    suspend <= 1'b0;
    power_fault <= 1'b1;
    k = 0;
    prev = power_activity_indicator;
    repeat (4 * BLINK + 4) begin
      @(posedge pclk);
      if (power_activity_indicator !== prev) k++;
      prev = power_activity_indicator;
    end
    chk("led blinks", 1'b1, k >= 3);
    mdl[OFF_STATUS] = 32'h00000008;
    rdc(OFF_STATUS);
    power_fault <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("led restored", 1'b1, power_activity_indicator);
    $display("led done");
    wr(OFF_DIR, 32'h00000001);
    rdc(OFF_DIR);
    chk("port drive", 8'hFF, line_oe[7:0]);
    chk("pull after dir", '1, pull_active);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("oe in reset", '0, line_oe);
    presetn <= 1'b1;
    repeat (14) @(posedge pclk);
    chk("oe after second reset", '0, line_oe);
    $display("reset done");
    close_out();
  end
endmodule : filtered_dio_change_detect_test

bind fdcd_top fdcd_monitor #(.BLINK_HALF(BLINK_HALF)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_oe(line_oe),
  .suspend(suspend), .power_fault(power_fault), .change_irq(change_irq),
  .change_overflow(change_overflow), .power_activity_indicator(power_activity_indicator)
);
